// ===== hw/gpp_consts.svh
// Purpose: Offsets, reset values, field positions and timing for the port pair
// Assumes: Word-wide register bus, 10 MHz system clock
// Notes: Offsets are byte addresses
`ifndef GPP_CONSTS_SVH
`define GPP_CONSTS_SVH
`define GPP_ADDR_W 16
`define GPP_OFF_A_DATA 16'hffd0
`define GPP_OFF_A_DIR 16'hffd2
`define GPP_OFF_B_DATA 16'hffd4
`define GPP_OFF_B_DIR 16'hffd6
`define GPP_OFF_A_DRV 16'hf1d2
`define GPP_OFF_B_DRV 16'hf1d6
`define GPP_OFF_A_PIN 16'hf1e0
`define GPP_OFF_B_PIN 16'hf1e2
`define GPP_OFF_A_CAPEV 16'hf1e4
`define GPP_REG_RESET 8'h00
`define GPP_PWM_LSB 0
`define GPP_CAP_LSB 4
`define GPP_SAMPLE_NS 200
`define GPP_CLK_MHZ 10
`define GPP_SAMPLE_CYC ((`GPP_SAMPLE_NS * `GPP_CLK_MHZ) / 1000)
`endif

// ===== hw/gpp_pkg.sv
// Purpose: Types shared by the port pair
// Assumes: Nothing
// Notes: Constants live in gpp_consts.svh
package gpp_pkg;
  typedef logic [7:0] gpp_byte_type;
  typedef enum logic [1:0] {
    GPP_ST_IDLE = 2'b00,
    GPP_ST_WAIT = 2'b01,
    GPP_ST_TAKE = 2'b10
  } gpp_samp_state_type;
endpackage : gpp_pkg

// ===== hw/gpp_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs asynchronous to sys_clk_i
// Notes: First stage read only by second stage
`timescale 1ns/1ps
`default_nettype none
module gpp_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } gpp_sync_state_type;
  gpp_sync_state_type st, next_st;
  always_comb begin
    next_st = st;
    next_st.meta = async_i;
    next_st.stable = st.meta;
    if (srst_i) begin
      next_st = '0;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    st <= next_st;
  end
  assign sync_o = st.stable;
endmodule : gpp_sync
`default_nettype wire

// ===== hw/gpp_pin_drv.sv
// Purpose: Per-line pin driver for one 8-bit port
// Assumes: Open-drain output enable high only while pulling low
// Notes: Outputs registered
`timescale 1ns/1ps
`default_nettype none
module gpp_pin_drv
  import gpp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Control
  input wire logic [WIDTH-1:0] level_i,
  input wire logic [WIDTH-1:0] dir_i,
  input wire logic [WIDTH-1:0] drv_i,
  // Pin
  output logic [WIDTH-1:0] pin_o,
  output logic [WIDTH-1:0] pin_oe_o
);
  typedef struct packed {
    logic [WIDTH-1:0] out;
    logic [WIDTH-1:0] oe;
  } gpp_drv_state_type;
  gpp_drv_state_type st, next_st;
  always_comb begin
    next_st.out = level_i;
    // Open drain drives only low; push-pull drives both levels
    next_st.oe = dir_i & (~drv_i | ~level_i);
    if (drv_i != '0) begin
      next_st.out = level_i & ~drv_i;
    end
    if (srst_i) begin
      next_st = '0;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    st <= next_st;
  end
  assign pin_o = st.out;
  assign pin_oe_o = st.oe;
  property p_input_hiz;
    @(posedge sys_clk_i) disable iff (srst_i)
      (dir_i == '0) |=> (pin_oe_o == '0);
  endproperty
  a_input_hiz: assert property (p_input_hiz)
    else $error("Input line driven");
  property p_od_high;
    @(posedge sys_clk_i) disable iff (srst_i)
      1'b1 |=> ((pin_oe_o & $past(drv_i) & $past(level_i)) == '0);
  endproperty
  a_od_high: assert property (p_od_high)
    else $error("Open drain line drove high");
endmodule : gpp_pin_drv
`default_nettype wire

// ===== hw/gpp_port_pair.sv
// Purpose: Two 8-bit GPIO ports with PWM and capture/compare pin functions
// Assumes: Plain register port, read data one cycle after strobe
// Notes: Pin readback and capture flags sit at spare offsets
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "gpp_consts.svh"
module gpp_port_pair
  import gpp_pkg::*;
#(
  parameter int SAMPLE_CYC = `GPP_SAMPLE_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [`GPP_ADDR_W-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // PWM unit outputs, already gated by its channel enables
  input wire logic pwm_out_ch0_i,
  input wire logic pwm_out_ch1_i,
  input wire logic pwm_out_ch2_i,
  input wire logic pwm_out_ch3_i,
  // Second capture/compare unit, channels a to d
  input wire logic [3:0] capcmp_cmp_event_i,
  input wire logic [3:0] capcmp_cmp_value_i,
  output logic [3:0] capcmp_pin_o,
  output logic [3:0] capcmp_ext_irq_o,
  // Port A pins
  input wire logic [7:0] port_a_pin_i,
  output logic [7:0] port_a_pin_o,
  output logic [7:0] port_a_pin_oe_o,
  // Port B pins
  input wire logic [7:0] port_b_pin_i,
  output logic [7:0] port_b_pin_o,
  output logic [7:0] port_b_pin_oe_o
);
  localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_CYC - 1);

  typedef struct packed {
    gpp_byte_type port_a_data;
    gpp_byte_type port_a_direction;
    gpp_byte_type port_a_drive_type;
    gpp_byte_type port_b_data;
    gpp_byte_type port_b_direction;
    gpp_byte_type port_b_drive_type;
    logic [7:0] samp_cnt;
    logic [3:0] cap_sample;
    logic [3:0] cap_irq;
    logic [3:0] cap_flag;
    logic [1:0] cap_warm;
    logic [15:0] rdata;
  } gpp_state_type;

  gpp_state_type st, next_st;
  logic [7:0] a_sync;
  logic [7:0] b_sync;
  logic [7:0] a_level;
  logic [3:0] pwm_vec;
  logic samp_tick;

  function automatic gpp_byte_type gpp_wr_byte(input gpp_byte_type cur, input logic hit,
                                               input logic [15:0] wd);
    gpp_wr_byte = hit ? wd[7:0] : cur;
  endfunction : gpp_wr_byte

  gpp_sync #(.WIDTH(8)) u_sync_a (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .async_i(port_a_pin_i),
    .sync_o(a_sync)
  );

  gpp_sync #(.WIDTH(8)) u_sync_b (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .async_i(port_b_pin_i),
    .sync_o(b_sync)
  );

  assign pwm_vec = {pwm_out_ch3_i, pwm_out_ch2_i, pwm_out_ch1_i, pwm_out_ch0_i};
  // Upper lines driven by latch, lower lines latch XOR PWM
  assign a_level = {st.port_a_data[7:4], st.port_a_data[3:0] ^ pwm_vec};
  assign samp_tick = (st.samp_cnt == SAMPLE_LAST);

  always_comb begin
    next_st = st;
    next_st.rdata = 16'h0000;
    next_st.port_a_data = gpp_wr_byte(st.port_a_data, wr_i && addr_i == `GPP_OFF_A_DATA, wdata_i);
    next_st.port_a_direction = gpp_wr_byte(st.port_a_direction, wr_i && addr_i == `GPP_OFF_A_DIR, wdata_i);
    next_st.port_a_drive_type = gpp_wr_byte(st.port_a_drive_type, wr_i && addr_i == `GPP_OFF_A_DRV, wdata_i);
    next_st.port_b_data = gpp_wr_byte(st.port_b_data, wr_i && addr_i == `GPP_OFF_B_DATA, wdata_i);
    next_st.port_b_direction = gpp_wr_byte(st.port_b_direction, wr_i && addr_i == `GPP_OFF_B_DIR, wdata_i);
    next_st.port_b_drive_type = gpp_wr_byte(st.port_b_drive_type, wr_i && addr_i == `GPP_OFF_B_DRV, wdata_i);
    // Compare event overrides a same-cycle software write per line
    for (int i = 0; i < 4; i++) begin
      if (capcmp_cmp_event_i[i]) begin
        next_st.port_a_data[`GPP_CAP_LSB + i] = capcmp_cmp_value_i[i];
      end
    end
    // Sample capture lines once per period
    next_st.cap_irq = 4'h0;
    if (samp_tick) begin
      next_st.samp_cnt = 8'h00;
    end else begin
      next_st.samp_cnt = st.samp_cnt + 8'h01;
    end
    // Follow pins until synchroniser is filled
    if (st.cap_warm != 2'h3) begin
      next_st.cap_warm = st.cap_warm + 2'h1;
      next_st.cap_sample = a_sync[7:4];
    end else if (samp_tick) begin
      next_st.cap_sample = a_sync[7:4];
      next_st.cap_irq = a_sync[7:4] & ~st.cap_sample;
    end
    // Sticky capture event flags, set wins over clear
    if (wr_i && addr_i == `GPP_OFF_A_CAPEV) begin
      next_st.cap_flag = st.cap_flag & ~wdata_i[3:0];
    end
    next_st.cap_flag = next_st.cap_flag | next_st.cap_irq;
    if (rd_i) begin
      unique case (addr_i)
        `GPP_OFF_A_DATA: next_st.rdata = {8'h00, st.port_a_data};
        `GPP_OFF_A_DIR: next_st.rdata = {8'h00, st.port_a_direction};
        `GPP_OFF_A_DRV: next_st.rdata = {8'h00, st.port_a_drive_type};
        `GPP_OFF_B_DATA: next_st.rdata = {8'h00, st.port_b_data};
        `GPP_OFF_B_DIR: next_st.rdata = {8'h00, st.port_b_direction};
        `GPP_OFF_B_DRV: next_st.rdata = {8'h00, st.port_b_drive_type};
        `GPP_OFF_A_PIN: next_st.rdata = {8'h00, a_sync};
        `GPP_OFF_B_PIN: next_st.rdata = {8'h00, b_sync};
        `GPP_OFF_A_CAPEV: next_st.rdata = {12'h000, st.cap_flag};
        default: next_st.rdata = 16'h0000;
      endcase
    end
    if (srst_i) begin
      next_st = '0;
      next_st.port_a_data = `GPP_REG_RESET;
      next_st.port_b_data = `GPP_REG_RESET;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    st <= next_st;
  end

  gpp_pin_drv #(.WIDTH(8)) u_drv_a (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .level_i(a_level),
    .dir_i(st.port_a_direction),
    .drv_i(st.port_a_drive_type),
    .pin_o(port_a_pin_o),
    .pin_oe_o(port_a_pin_oe_o)
  );

  gpp_pin_drv #(.WIDTH(8)) u_drv_b (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .level_i(st.port_b_data),
    .dir_i(st.port_b_direction),
    .drv_i(st.port_b_drive_type),
    .pin_o(port_b_pin_o),
    .pin_oe_o(port_b_pin_oe_o)
  );

  assign rdata_o = st.rdata;
  assign capcmp_pin_o = a_sync[7:4];
  assign capcmp_ext_irq_o = st.cap_irq;

  property p_reset_clear;
    @(posedge sys_clk_i) srst_i |=> (st.port_a_data == 8'h00 && st.port_a_direction == 8'h00 &&
      st.port_a_drive_type == 8'h00 && st.port_b_data == 8'h00 && st.port_b_direction == 8'h00 &&
      st.port_b_drive_type == 8'h00);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("Registers not cleared by reset");

  property p_upper_zero;
    @(posedge sys_clk_i) disable iff (srst_i) rd_i |=> (rdata_o[15:8] == 8'h00);
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("Upper byte not zero");

  property p_dir_readback;
    @(posedge sys_clk_i) disable iff (srst_i)
      (wr_i && addr_i == `GPP_OFF_A_DIR) ##1 (rd_i && addr_i == `GPP_OFF_A_DIR && !wr_i)
      |=> (rdata_o[7:0] == $past(wdata_i, 2));
  endproperty
  a_dir_readback: assert property (p_dir_readback)
    else $error("Direction readback wrong");

  property p_pwm_xor;
    @(posedge sys_clk_i) disable iff (srst_i)
      1'b1 |=> ((((port_a_pin_o[3:0] ^ $past(st.port_a_data[3:0])) ^ $past(pwm_vec)) &
        $past(st.port_a_direction[3:0]) & ~$past(st.port_a_drive_type[3:0])) == 4'h0);
  endproperty
  a_pwm_xor: assert property (p_pwm_xor)
    else $error("PWM lines not XOR of latch");

  property p_pwm_pin;
    @(posedge sys_clk_i) disable iff (srst_i)
      (st.port_a_direction[0] && !st.port_a_drive_type[0] && !srst_i)
      |=> (port_a_pin_o[0] == ($past(st.port_a_data[0]) ^ $past(pwm_out_ch0_i)));
  endproperty
  a_pwm_pin: assert property (p_pwm_pin)
    else $error("PWM channel 0 not on line 0");

  property p_cmp_load;
    @(posedge sys_clk_i) disable iff (srst_i)
      capcmp_cmp_event_i[0] |=> (st.port_a_data[4] == $past(capcmp_cmp_value_i[0]));
  endproperty
  a_cmp_load: assert property (p_cmp_load)
    else $error("Compare value not loaded");

  property p_sample_period;
    @(posedge sys_clk_i) disable iff (srst_i) samp_tick |=> !samp_tick;
  endproperty
  a_sample_period: assert property (p_sample_period)
    else $error("Sample period too short");

  property p_sample_bound;
    @(posedge sys_clk_i) disable iff (srst_i) st.samp_cnt <= SAMPLE_LAST;
  endproperty
  a_sample_bound: assert property (p_sample_bound)
    else $error("Sample counter overran");

  property p_cap_route;
    @(posedge sys_clk_i) disable iff (srst_i)
      (!$past(srst_i) && !$past(srst_i, 2)) |-> (capcmp_pin_o == $past(port_a_pin_i[7:4], 2));
  endproperty
  a_cap_route: assert property (p_cap_route)
    else $error("Capture routing wrong");

  property p_irq_quiet;
    @(posedge sys_clk_i) disable iff (srst_i)
      $fell(srst_i) |-> (capcmp_ext_irq_o == 4'h0) [*4];
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("Interrupt right after reset");

  property p_a_input_hiz;
    @(posedge sys_clk_i) disable iff (srst_i)
      1'b1 |=> ((port_a_pin_oe_o & ~$past(st.port_a_direction)) == 8'h00);
  endproperty
  a_a_input_hiz: assert property (p_a_input_hiz)
    else $error("Port A input line driven");

  property p_b_input_hiz;
    @(posedge sys_clk_i) disable iff (srst_i)
      1'b1 |=> ((port_b_pin_oe_o & ~$past(st.port_b_direction)) == 8'h00);
  endproperty
  a_b_input_hiz: assert property (p_b_input_hiz)
    else $error("Port B input line driven");

  property p_a_pp_driven;
    @(posedge sys_clk_i) disable iff (srst_i)
      1'b1 |=> ((~port_a_pin_oe_o & $past(st.port_a_direction) & ~$past(st.port_a_drive_type)) == 8'h00);
  endproperty
  a_a_pp_driven: assert property (p_a_pp_driven)
    else $error("Port A push-pull output not driven");

  property p_b_pp_driven;
    @(posedge sys_clk_i) disable iff (srst_i)
      1'b1 |=> ((~port_b_pin_oe_o & $past(st.port_b_direction) & ~$past(st.port_b_drive_type)) == 8'h00);
  endproperty
  a_b_pp_driven: assert property (p_b_pp_driven)
    else $error("Port B push-pull output not driven");

  property p_a_od_low;
    @(posedge sys_clk_i) disable iff (srst_i)
      1'b1 |=> ((port_a_pin_o & $past(st.port_a_drive_type)) == 8'h00);
  endproperty
  a_a_od_low: assert property (p_a_od_low)
    else $error("Port A open drain level high");

  property p_b_od_low;
    @(posedge sys_clk_i) disable iff (srst_i)
      1'b1 |=> ((port_b_pin_o & $past(st.port_b_drive_type)) == 8'h00);
  endproperty
  a_b_od_low: assert property (p_b_od_low)
    else $error("Port B open drain level high");

  property p_b_level;
    @(posedge sys_clk_i) disable iff (srst_i)
      1'b1 |=> (((port_b_pin_o ^ $past(st.port_b_data)) & $past(st.port_b_direction) &
        ~$past(st.port_b_drive_type)) == 8'h00);
  endproperty
  a_b_level: assert property (p_b_level)
    else $error("Port B output not latch level");

  property p_cap_level;
    @(posedge sys_clk_i) disable iff (srst_i)
      1'b1 |=> (((port_a_pin_o[7:4] ^ $past(st.port_a_data[7:4])) & $past(st.port_a_direction[7:4]) &
        ~$past(st.port_a_drive_type[7:4])) == 4'h0);
  endproperty
  a_cap_level: assert property (p_cap_level)
    else $error("Compare line not latch level");

  property p_rd_idle;
    @(posedge sys_clk_i) disable iff (srst_i) !rd_i |=> (rdata_o == 16'h0000);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("Read data without read");

  property p_irq_on_tick;
    @(posedge sys_clk_i) disable iff (srst_i) !samp_tick |=> (capcmp_ext_irq_o == 4'h0);
  endproperty
  a_irq_on_tick: assert property (p_irq_on_tick)
    else $error("Interrupt between samples");

  property p_irq_rise;
    @(posedge sys_clk_i) disable iff (srst_i) 1'b1 |-> ((capcmp_ext_irq_o & ~st.cap_sample) == 4'h0);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("Interrupt on low sample");

  property p_flag_has_irq;
    @(posedge sys_clk_i) disable iff (srst_i) 1'b1 |-> ((capcmp_ext_irq_o & ~st.cap_flag) == 4'h0);
  endproperty
  a_flag_has_irq: assert property (p_flag_has_irq)
    else $error("Interrupt without flag");

  property p_flag_hold;
    @(posedge sys_clk_i) disable iff (srst_i)
      !(wr_i && addr_i == `GPP_OFF_A_CAPEV) |=> ((~st.cap_flag & $past(st.cap_flag)) == 4'h0);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("Capture flag lost");

  property p_b_hold;
    @(posedge sys_clk_i) disable iff (srst_i)
      !wr_i |=> $stable({st.port_b_data, st.port_b_direction, st.port_b_drive_type});
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("Port B register changed without write");
endmodule : gpp_port_pair
`default_nettype wire

// ===== verification/gpp_pin_model.sv
// Purpose: External circuit on the pins of one port
// Assumes: Pull-up on every line
// Notes: A released line reads high
`timescale 1ns/1ps
`default_nettype none
module gpp_pin_model (
  // Device side
  input wire logic [7:0] pin_i,
  input wire logic [7:0] pin_oe_i,
  // Stimulus side
  input wire logic [7:0] ext_lvl_i,
  input wire logic [7:0] ext_en_i,
  // Resolved pad level
  output logic [7:0] pad_o
);
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      if (pin_oe_i[k]) begin
        pad_o[k] = pin_i[k];
      end else if (ext_en_i[k]) begin
        pad_o[k] = ext_lvl_i[k];
      end else begin
        pad_o[k] = 1'b1;
      end
    end
  end
endmodule : gpp_pin_model
`default_nettype wire

// ===== verification/gpp_port_pair_tb_top.sv
// Purpose: Self-checking bench for the port pair
// Assumes: Default sample interval
// Notes: Pins resolved by the pin model
`timescale 1ns/1ps
`default_nettype none
`include "gpp_consts.svh"
module gpp_port_pair_tb_top;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic [3:0] pwm = 4'h0;
  logic [3:0] cmp_ev = 4'h0;
  logic [3:0] cmp_val = 4'h0;
  logic [3:0] cap_pin, cap_irq;
  logic [7:0] a_pin, a_oe, b_pin, b_oe, a_pad, b_pad;
  logic [7:0] ext_lvl = 8'h00;
  logic [7:0] ext_en = 8'h00;
  logic [15:0] offs [6] = '{`GPP_OFF_A_DATA, `GPP_OFF_A_DIR, `GPP_OFF_A_DRV,
                            `GPP_OFF_B_DATA, `GPP_OFF_B_DIR, `GPP_OFF_B_DRV};
  int n_errors = 0;
  int samples_checked = 0;

  gpp_port_pair u_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pwm_out_ch0_i(pwm[0]), .pwm_out_ch1_i(pwm[1]),
    .pwm_out_ch2_i(pwm[2]), .pwm_out_ch3_i(pwm[3]), .capcmp_cmp_event_i(cmp_ev),
    .capcmp_cmp_value_i(cmp_val), .capcmp_pin_o(cap_pin), .capcmp_ext_irq_o(cap_irq),
    .port_a_pin_i(a_pad), .port_a_pin_o(a_pin), .port_a_pin_oe_o(a_oe),
    .port_b_pin_i(b_pad), .port_b_pin_o(b_pin), .port_b_pin_oe_o(b_oe));
  gpp_pin_model u_pins_a (.pin_i(a_pin), .pin_oe_i(a_oe), .ext_lvl_i(ext_lvl), .ext_en_i(ext_en), .pad_o(a_pad));
  gpp_pin_model u_pins_b (.pin_i(b_pin), .pin_oe_i(b_oe), .ext_lvl_i(8'h00), .ext_en_i(8'h00), .pad_o(b_pad));

  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string what);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(what, rdata_o, exp);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : settle

  task automatic give_verdict;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic t_reset;
    foreach (offs[i]) rd(offs[i], 16'h0000, "reset value");
    chk("oe after reset", {a_oe, b_oe}, 16'h0000);
  endtask : t_reset

  task automatic t_regs;
    foreach (offs[i]) begin
      wr(offs[i], 16'hffff);
      rd(offs[i], 16'h00ff, "register width");
      wr(offs[i], 16'h0000);
    end
    wr(16'h1230, 16'h00ff);
    rd(16'h1230, 16'h0000, "unmapped");
  endtask : t_regs

  task automatic t_b2b;
    @(posedge sys_clk_i);
    addr_i <= `GPP_OFF_A_DIR;
    wdata_i <= 16'h00c3;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    chk("back-to-back read", rdata_o, 16'h00c3);
    wr(`GPP_OFF_A_DIR, 16'h0000);
  endtask : t_b2b

  task automatic t_drive;
    wr(`GPP_OFF_B_DATA, 16'h00a5);
    wr(`GPP_OFF_B_DIR, 16'h00ff);
    settle(3);
    chk("push-pull pins", {b_pin, b_oe}, 16'ha5ff);
    wr(`GPP_OFF_B_DRV, 16'h00ff);
    settle(3);
    chk("open-drain pins", {b_pin, b_oe}, 16'h005a);
    rd(`GPP_OFF_B_PIN, 16'h00a5, "pad readback");
    wr(`GPP_OFF_B_DIR, 16'h000f);
    settle(3);
    chk("partial outputs", {8'h00, b_oe}, 16'h000a);
  endtask : t_drive

  task automatic t_pwm;
    logic [3:0] latch;
    wr(`GPP_OFF_A_DIR, 16'h000f);
    for (int l = 0; l < 2; l++) begin
      latch = l[0] ? 4'hf : 4'h0;
      wr(`GPP_OFF_A_DATA, {12'h000, latch});
      for (int p = 0; p < 16; p++) begin
        @(posedge sys_clk_i);
        pwm <= p[3:0];
        settle(3);
        chk("pwm pins", {12'h000, a_pin[3:0]}, {12'h000, latch ^ p[3:0]});
      end
    end
    wr(`GPP_OFF_A_DRV, 16'h000f);
    @(posedge sys_clk_i);
    pwm <= 4'h5;
    settle(3);
    chk("pwm open drain", {8'h00, a_pin[3:0], a_oe[3:0]}, 16'h0005);
    wr(`GPP_OFF_A_DRV, 16'h0000);
  endtask : t_pwm

  task automatic watch(input int n, output logic [3:0] seen, output int cnt);
    seen = 4'h0;
    cnt = 0;
    repeat (n) begin
      @(posedge sys_clk_i);
      #1;
      seen = seen | cap_irq;
      if (cap_irq !== 4'h0) cnt++;
    end
  endtask : watch

  task automatic t_capture;
    logic [3:0] seen;
    int cnt;
    wr(`GPP_OFF_A_DIR, 16'h0000);
    ext_en <= 8'hf0;
    settle(8);
    for (int c = 0; c < 4; c++) begin
      ext_lvl <= 8'h10 << c;
      watch(12, seen, cnt);
      chk("capture irq", {seen, cap_pin, 8'(cnt)}, {4'h1 << c, 4'h1 << c, 8'h01});
      ext_lvl <= 8'h00;
      watch(12, seen, cnt);
      chk("no irq on fall", {12'h000, seen}, 16'h0000);
    end
    rd(`GPP_OFF_A_PIN, 16'h000f, "pin readback");
    rd(`GPP_OFF_A_CAPEV, 16'h000f, "capture flags");
    wr(`GPP_OFF_A_CAPEV, 16'h000f);
    rd(`GPP_OFF_A_CAPEV, 16'h0000, "flags cleared");
  endtask : t_capture

  task automatic t_compare;
    logic [3:0] acc;
    acc = 4'h0;
    ext_en <= 8'h00;
    wr(`GPP_OFF_A_DIR, 16'h00f0);
    wr(`GPP_OFF_A_DATA, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      @(posedge sys_clk_i);
      cmp_ev <= 4'h1 << c;
      cmp_val <= 4'hf;
      @(posedge sys_clk_i);
      cmp_ev <= 4'h0;
      acc = acc | (4'h1 << c);
      settle(3);
      chk("compare pins", {12'h000, a_pin[7:4]}, {12'h000, acc});
    end
    rd(`GPP_OFF_A_DATA, 16'h00f0, "compare latch");
    @(posedge sys_clk_i);
    addr_i <= `GPP_OFF_A_DATA;
    wdata_i <= 16'h00f0;
    wr_i <= 1'b1;
    cmp_ev <= 4'h1;
    cmp_val <= 4'h0;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    cmp_ev <= 4'h0;
    rd(`GPP_OFF_A_DATA, 16'h00e0, "compare beats write");
    wr(`GPP_OFF_A_DATA, 16'h0000);
    rd(`GPP_OFF_A_DATA, 16'h0000, "software write");
  endtask : t_compare

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_regs();
    t_b2b();
    t_drive();
    t_pwm();
    t_capture();
    t_compare();
    wr(`GPP_OFF_B_DRV, 16'h0033);
    @(posedge sys_clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    t_reset();
    give_verdict();
  end
endmodule : gpp_port_pair_tb_top
`default_nettype wire
